// File: bcmcw_pkg.sv
// package: offset, bit positions, reset value and enumerations of the message control word
package bcmcw_pkg;

  localparam logic [15:0] BCMCW_OFFSET      = 16'h0004;
  localparam logic [15:0] BCMCW_RESET       = 16'h0000;
  localparam int          BCMCW_SYNC_TT_BIT = 15;
  localparam int          BCMCW_ME_BIT      = 14;
  localparam int          BCMCW_SRQ_BIT     = 13;
  localparam int          BCMCW_BSY_BIT     = 12;
  localparam int          BCMCW_SSF_BIT     = 11;
  localparam int          BCMCW_RSV_BIT     = 9;
  localparam int          BCMCW_TF_BIT      = 10;
  localparam int          BCMCW_RETRY_BIT   = 8;
  localparam int          BCMCW_BUSA_BIT    = 7;
  localparam int          BCMCW_LOOP_BIT    = 6;
  localparam int          BCMCW_BCR_BIT     = 5;
  localparam int          BCMCW_EOM_BIT     = 4;
  localparam int          BCMCW_REV_BIT     = 3;
  localparam int          BCMCW_FMT_LSB     = 0;

  // status word bit positions (bus order, bit 0 = last bit sent)
  localparam int          BCMCW_SW_ME       = 10;
  localparam int          BCMCW_SW_SRQ      = 8;
  localparam int          BCMCW_SW_RSV_LSB  = 5;
  localparam int          BCMCW_SW_BCR      = 4;
  localparam int          BCMCW_SW_BSY      = 3;
  localparam int          BCMCW_SW_SSF      = 2;
  localparam int          BCMCW_SW_TF       = 0;

  typedef enum logic [2:0]
  {
    BCMCW_FMT_BC_TO_RT     = 3'b000,
    BCMCW_FMT_RT_TO_RT     = 3'b001,
    BCMCW_FMT_BCAST        = 3'b010,
    BCMCW_FMT_BCAST_RT_RT  = 3'b011,
    BCMCW_FMT_MODE         = 3'b100,
    BCMCW_FMT_UNUSED_5     = 3'b101,
    BCMCW_FMT_BCAST_MODE   = 3'b110,
    BCMCW_FMT_UNUSED_7     = 3'b111
  } bcmcw_fmt_type;

endpackage : bcmcw_pkg

// File: bcmcw_control_word.sv
// message control word register and its decode into message handling controls
//
// Summary of operation
// - 16-bit read/write word at 0x0004, reset zero, first word of each message block.
// - the word is never transmitted; it only configures message handling.
// - bit 15 clear: sync mode data word comes from the message data block.
// - bit 15 set: sync data from time tag; host also sets config bit.
// - bit 14 set masks message error status bit, clear recognises it.
// - bit 13 set masks service request status bit, clear recognises it.
// - bit 12 set masks busy status bit, clear recognises it.
// - bit 11 set masks subsystem flag status bit, clear recognises it.
// - bit 10 set masks terminal flag status bit, clear recognises it.
// - bit 9 clear flags any of three reserved status bits set.
// - bit 5 set masks broadcast received status bit, clear recognises it.
// - bit 8 set allows retry of failed messages, clear forbids retry.
// - bit 7 one selects bus A, zero selects bus B.
// - bit 6 set runs message as internal loopback, transmission disabled.
// - bit 4 set requests interrupt at message end unless masked.
// - bit 3 one expects 1553A responses, zero 1553B responses.
// - bits 2..0 decode the message format; 101 and 111 unused.
module bcmcw_control_word
  import bcmcw_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // host register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  // message sequencer inputs
  input  wire logic        status_valid_in,
  input  wire logic [10:0] status_word_in,
  input  wire logic        message_done_in,
  input  wire logic        eom_irq_enable_in,
  input  wire logic [15:0] data_block_word_in,
  input  wire logic [15:0] time_tag_in,
  input  wire logic        time_tag_sync_enable_in,
  input  wire logic        message_failed_in,
  // decoded message controls
  output logic             sync_data_from_time_tag_out,
  output logic [15:0]      sync_data_word_out,
  output logic             channel_a_select_out,
  output logic             channel_b_select_out,
  output logic             transmit_enable_out,
  output logic             offline_loopback_out,
  output logic             retry_allow_out,
  output logic             retry_request_out,
  output logic             response_revision_select_out,
  output bcmcw_fmt_type    message_format_code_out,
  output logic             format_error_out,
  output logic             status_exception_out,
  output logic             reserved_status_out,
  output logic [6:0]       status_flags_out,
  output logic             message_end_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register
  logic [15:0] ctrl_word_r;
  logic [15:0] ctrl_word_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [6:0]  flags_r;
  logic [6:0]  flags_nxt;
  logic        exc_r;
  logic        rsv_r;
  logic        irq_r;
  logic        retry_r;
  logic        sel_hit;

  assign sel_hit = (reg_addr_in == BCMCW_OFFSET);

  assign ctrl_word_nxt = (sel_hit && reg_wr_in) ? reg_wdata_in : ctrl_word_r;
  assign rdata_nxt     = (sel_hit && reg_rd_in) ? ctrl_word_r : 16'h0000;

  // word storage and read data
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctrl_word_r <= BCMCW_RESET;
      rdata_r     <= 16'h0000;
    end
    else
    begin
      ctrl_word_r <= ctrl_word_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  logic tt_sel;
  assign tt_sel = ctrl_word_r[BCMCW_SYNC_TT_BIT];

  assign sync_data_from_time_tag_out = tt_sel && time_tag_sync_enable_in;
  assign sync_data_word_out = sync_data_from_time_tag_out ? time_tag_in : data_block_word_in;

  assign channel_a_select_out = ctrl_word_r[BCMCW_BUSA_BIT];
  assign channel_b_select_out = !ctrl_word_r[BCMCW_BUSA_BIT];

  assign offline_loopback_out = ctrl_word_r[BCMCW_LOOP_BIT];
  assign transmit_enable_out  = !ctrl_word_r[BCMCW_LOOP_BIT];

  assign retry_allow_out = ctrl_word_r[BCMCW_RETRY_BIT];

  assign response_revision_select_out = ctrl_word_r[BCMCW_REV_BIT];

  assign message_format_code_out = bcmcw_fmt_type'(ctrl_word_r[BCMCW_FMT_LSB +: 3]);

  assign format_error_out = (message_format_code_out == BCMCW_FMT_UNUSED_5) ||
                            (message_format_code_out == BCMCW_FMT_UNUSED_7);

  ////////////////////////////////////////////////////////////////////////////
  // status word masking
  logic [6:0] masked_flags;
  logic       rsv_seen;

  // a status bit counts only while its mask bit is clear
  function automatic logic seen_unless_masked(input logic status_bit, input logic mask_bit);
    return status_bit && !mask_bit;
  endfunction : seen_unless_masked

  assign rsv_seen = seen_unless_masked(|status_word_in[BCMCW_SW_RSV_LSB +: 3],
                                       ctrl_word_r[BCMCW_RSV_BIT]);

  assign masked_flags[0] = seen_unless_masked(status_word_in[BCMCW_SW_ME],
                                              ctrl_word_r[BCMCW_ME_BIT]);
  assign masked_flags[1] = seen_unless_masked(status_word_in[BCMCW_SW_SRQ],
                                              ctrl_word_r[BCMCW_SRQ_BIT]);
  assign masked_flags[2] = seen_unless_masked(status_word_in[BCMCW_SW_BSY],
                                              ctrl_word_r[BCMCW_BSY_BIT]);
  assign masked_flags[3] = seen_unless_masked(status_word_in[BCMCW_SW_SSF],
                                              ctrl_word_r[BCMCW_SSF_BIT]);
  assign masked_flags[4] = seen_unless_masked(status_word_in[BCMCW_SW_TF],
                                              ctrl_word_r[BCMCW_TF_BIT]);
  assign masked_flags[5] = rsv_seen;
  assign masked_flags[6] = seen_unless_masked(status_word_in[BCMCW_SW_BCR],
                                              ctrl_word_r[BCMCW_BCR_BIT]);

  assign flags_nxt = status_valid_in ? masked_flags : flags_r;

  // status capture, end-of-message interrupt and retry request
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      flags_r <= 7'h00;
      exc_r   <= 1'b0;
      rsv_r   <= 1'b0;
      irq_r   <= 1'b0;
      retry_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      exc_r   <= |flags_nxt;
      rsv_r   <= flags_nxt[5];
      irq_r   <= message_done_in && ctrl_word_r[BCMCW_EOM_BIT] && eom_irq_enable_in;
      retry_r <= message_failed_in && ctrl_word_r[BCMCW_RETRY_BIT];
    end
  end

  assign status_flags_out     = flags_r;
  assign status_exception_out = exc_r;
  assign reserved_status_out  = rsv_r;
  assign message_end_irq_out  = irq_r;
  assign retry_request_out    = retry_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_word_write_stores: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    reg_wr_in && sel_hit |=> ctrl_word_r == $past(reg_wdata_in))
    else $error("control word did not take the write");

  a_other_addr_ignored: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    reg_wr_in && !sel_hit |=> $stable(ctrl_word_r))
    else $error("write to another address changed the word");

  a_read_returns_word: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    reg_rd_in && sel_hit && !reg_wr_in ##1 !reg_wr_in |-> reg_rdata_out == ctrl_word_r)
    else $error("read data differs from stored word");

  a_bus_select_excl: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    channel_a_select_out != channel_b_select_out)
    else $error("bus select not exclusive");

  a_loopback_no_tx: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    offline_loopback_out |-> !transmit_enable_out)
    else $error("transmission enabled in loopback");

  a_sync_from_block: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !ctrl_word_r[BCMCW_SYNC_TT_BIT] |-> sync_data_word_out == data_block_word_in)
    else $error("sync data not from data block");

  a_sync_from_tag: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ctrl_word_r[BCMCW_SYNC_TT_BIT] && time_tag_sync_enable_in
    |-> sync_data_word_out == time_tag_in)
    else $error("sync data not from time tag");

  a_me_mask: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && status_word_in[BCMCW_SW_ME] && !ctrl_word_r[BCMCW_ME_BIT]
    |=> status_flags_out[0] && status_exception_out)
    else $error("message error not recognised");

  a_me_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_ME_BIT] |=> !status_flags_out[0])
    else $error("message error flagged while masked");

  a_srq_seen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && status_word_in[BCMCW_SW_SRQ] && !ctrl_word_r[BCMCW_SRQ_BIT]
    |=> status_flags_out[1] && status_exception_out)
    else $error("service request not recognised");

  a_srq_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_SRQ_BIT] |=> !status_flags_out[1])
    else $error("service request flagged while masked");

  a_busy_seen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && status_word_in[BCMCW_SW_BSY] && !ctrl_word_r[BCMCW_BSY_BIT]
    |=> status_flags_out[2] && status_exception_out)
    else $error("busy not recognised");

  a_busy_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_BSY_BIT] |=> !status_flags_out[2])
    else $error("busy flagged while masked");

  a_subsys_seen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && status_word_in[BCMCW_SW_SSF] && !ctrl_word_r[BCMCW_SSF_BIT]
    |=> status_flags_out[3] && status_exception_out)
    else $error("subsystem flag not recognised");

  a_subsys_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_SSF_BIT] |=> !status_flags_out[3])
    else $error("subsystem flag flagged while masked");

  a_term_flag_seen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && status_word_in[BCMCW_SW_TF] && !ctrl_word_r[BCMCW_TF_BIT]
    |=> status_flags_out[4] && status_exception_out)
    else $error("terminal flag not recognised");

  a_term_flag_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_TF_BIT] |=> !status_flags_out[4])
    else $error("terminal flag flagged while masked");

  a_rsv_seen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && (|status_word_in[BCMCW_SW_RSV_LSB +: 3]) && !ctrl_word_r[BCMCW_RSV_BIT]
    |=> reserved_status_out && status_flags_out[5])
    else $error("reserved status not recognised");

  a_rsv_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_RSV_BIT] |=> !reserved_status_out)
    else $error("reserved status flagged while masked");

  a_bcast_seen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && status_word_in[BCMCW_SW_BCR] && !ctrl_word_r[BCMCW_BCR_BIT]
    |=> status_flags_out[6] && status_exception_out)
    else $error("broadcast received not recognised");

  a_bcast_masked: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    status_valid_in && ctrl_word_r[BCMCW_BCR_BIT] |=> !status_flags_out[6])
    else $error("broadcast received flagged while masked");

  a_retry_on_fail: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    message_failed_in |=> retry_request_out == $past(ctrl_word_r[BCMCW_RETRY_BIT]))
    else $error("retry request does not follow retry bit");

  a_retry_quiet: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !message_failed_in |=> !retry_request_out)
    else $error("retry requested without a failure");

  a_eom_irq: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    message_done_in && eom_irq_enable_in && ctrl_word_r[BCMCW_EOM_BIT]
    |=> message_end_irq_out ##1 (message_end_irq_out ==
      $past(message_done_in && eom_irq_enable_in && ctrl_word_r[BCMCW_EOM_BIT])))
    else $error("end of message interrupt wrong");

  a_eom_irq_quiet: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !(message_done_in && eom_irq_enable_in && ctrl_word_r[BCMCW_EOM_BIT])
    |=> !message_end_irq_out)
    else $error("end of message interrupt without cause");

  a_format_error: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    format_error_out |-> ctrl_word_r[2] && ctrl_word_r[0])
    else $error("format error on valid code");

endmodule : bcmcw_control_word

// File: bcmcw_rt_model.sv
// remote terminal stand-in: answers each message with one status word
module bcmcw_rt_model
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // request from the bench, a one-cycle pulse taken while the terminal is idle
  input  wire logic        req_in,
  input  wire logic        slow_in,
  input  wire logic        fail_in,
  input  wire logic [10:0] sw_in,
  // answer toward the block
  output logic             valid_out,
  output logic             done_out,
  output logic             failed_out,
  output logic [10:0]      word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_r;
  logic       busy_r;
  logic       sent_r;
  ////////////////////////////////////////////////////////////////////////////////
  // word lines toggle outside the answer so a stale status never looks valid
  always_ff @(posedge clk_sys_in)
  begin
    valid_out  <= 1'b0;
    done_out   <= 1'b0;
    failed_out <= 1'b0;
    word_out   <= ~word_out;
    if (reset_in)
    begin
      busy_r   <= 1'b0;
      sent_r   <= 1'b0;
      word_out <= 11'h7ff;
    end
    else if (req_in && !busy_r)
    begin
      busy_r <= 1'b1;
      wait_r <= slow_in ? 3'h5 : 3'h0; // slow terminal takes five extra cycles
    end
    else if (busy_r && wait_r != 3'h0)
      wait_r <= wait_r - 3'h1;
    else if (busy_r && !sent_r)
    begin
      valid_out <= 1'b1;
      word_out  <= sw_in;
      sent_r    <= 1'b1;
    end
    else if (busy_r)
    begin
      done_out   <= !fail_in;
      failed_out <= fail_in;
      busy_r     <= 1'b0;
      sent_r     <= 1'b0;
    end
  end
endmodule : bcmcw_rt_model

// File: tb.sv
// self-checking bench for the message control word block
module tb import bcmcw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, req = 0, slow = 0, fail = 0, ien = 0, ten = 0;
  logic        rd_seen = 0, sv_seen = 0, mv, md, mf;
  logic [15:0] addr = 0, wdata = 0, db = 0, tt = 0, w, rdata, rq[$], fq[$];
  logic [10:0] sw = 0, mw;
  logic [31:0] r = 32'h0000_a3ab;
  int          n_fail = 0, checks_done = 0, k;
  wire  [10:0] o;
  wire  [8:0]  s;
  wire  [15:0] syw;
  wire         irq, rr;
  always #5 clk = ~clk;
  bcmcw_control_word dut (.clk_sys_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .status_valid_in(mv),
    .status_word_in(mw), .message_done_in(md), .eom_irq_enable_in(ien), .data_block_word_in(db),
    .time_tag_in(tt), .time_tag_sync_enable_in(ten), .message_failed_in(mf),
    .sync_data_from_time_tag_out(o[10]), .sync_data_word_out(syw), .channel_a_select_out(o[9]),
    .channel_b_select_out(o[8]), .transmit_enable_out(o[7]), .offline_loopback_out(o[6]),
    .retry_allow_out(o[5]), .retry_request_out(rr), .response_revision_select_out(o[4]),
    .message_format_code_out(o[2:0]), .format_error_out(o[3]), .status_exception_out(s[7]),
    .reserved_status_out(s[8]), .status_flags_out(s[6:0]), .message_end_irq_out(irq));
  bcmcw_rt_model rt (.clk_sys_in(clk), .reset_in(rst), .req_in(req), .slow_in(slow),
    .fail_in(fail), .sw_in(sw), .valid_out(mv), .done_out(md), .failed_out(mf), .word_out(mw));
  ////////////////////////////////////////////////////////////////////////////////
  // helpers: random source, expected status flags, compare, verdict
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [15:0] flg(logic [15:0] c, logic [10:0] t);
    logic [6:0] f;
    f = {t[4] & ~c[5], |t[7:5] & ~c[9], t[0] & ~c[10], t[2] & ~c[11], t[3] & ~c[12],
         t[8] & ~c[13], t[10] & ~c[14]};
    return {6'h0, 1'b0, |f[5], |f, f};
  endfunction : flg
  task automatic chk(logic [15:0] got, logic [15:0] exp, string m);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // register cycles: strobe held for one edge, expected read value noted in the queue
  task automatic wr_reg(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    #1 {addr, wdata, wr} = {a, d, 1'b1};
    @(posedge clk);
    #1 wr = 0;
  endtask : wr_reg
  task automatic rd_reg(logic [15:0] a, logic [15:0] e);
    rq.push_back(e);
    @(posedge clk);
    #1 {addr, rd} = {a, 1'b1};
    @(posedge clk);
    #1 rd = 0;
  endtask : rd_reg
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: takes the oldest note whenever a read or a status result appears
  always @(posedge clk)
  begin
    rd_seen <= rd;
    sv_seen <= mv;
  end
  always @(negedge clk)
  begin
    if (rd_seen) chk(rdata, rq.pop_front(), "read data");
    if (sv_seen) chk({7'h0, s}, fq.pop_front(), "status flags");
  end
  // main sequence: random control words, every format code, both terminal speeds
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    rd_reg(BCMCW_OFFSET, BCMCW_RESET);
    for (int i = 0; i < 24; i++)
    begin
      r = nxt(r);
      w = r[15:0];
      if (i < 8) w[2:0] = i[2:0];
      db = r[31:16];
      r = nxt(r);
      {sw, fail, slow, ien, ten, tt} = r[30:0];
      wr_reg(BCMCW_OFFSET, w);
      wr_reg(16'h0003, ~w);
      chk({5'h0, o}, {5'h0, w[15] & ten, w[7], ~w[7], ~w[6], w[6], w[8], w[3], w[2] & w[0],
          w[2:0]}, "decode");
      chk(syw, (w[15] & ten) ? tt : db, "sync word");
      rd_reg(BCMCW_OFFSET, w);
      rd_reg(16'h0005, 16'h0000);
      fq.push_back(flg(w, sw));
      @(posedge clk);
      #1 req = 1;
      @(posedge clk);
      #1 req = 0;
      k = 0;
      while (!(md || mf))
      begin
        @(posedge clk);
        #1 k++;
        if (k > 20)
        begin
          n_fail++;
          tally_and_finish();
        end
      end
      @(posedge clk);
      #1 chk({14'h0, irq, rr}, {14'h0, ~fail & w[4] & ien, fail & w[8]}, "pulses");
    end
    tally_and_finish();
  end
endmodule : tb
